// file: pkg/clk_ctrl_pkg.sv
// Package: constants for the halt clock and power-mode controller.
// Assumes a single 100 MHz system clock stands in for the oscillator.
package clk_ctrl_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // Warm-up: 2^14 + 2.5 clock periods, held as half periods
  localparam int WARM_HALF_PERIODS = 32773;
  localparam int WARM_CYCLES = (WARM_HALF_PERIODS + 1) / 2;
  localparam int CLK_DIV_BY = 2;
  // ----------------------------------------
  // Power modes {power_mode_select_a, power_mode_select_b}
  // ----------------------------------------
  localparam logic [1:0] MODE_LIGHT_SLEEP = 2'h0;
  localparam logic [1:0] MODE_CLOCK_OUT_SLEEP = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_RUN = 2'h3;
  // ----------------------------------------
  // Machine cycle state and power-mode state
  // ----------------------------------------
  localparam logic [1:0] FOURTH_STATE = 2'h3;
  typedef enum logic [1:0] {PM_ACTIVE, PM_IDLE, PM_STOP, PM_WARM} pm_state_e;
endpackage

// file: pkg/clk_gate_if.sv
// Interface: clock-gating controls between the controller and its divider.
// Assumes one clock domain.
`timescale 1ns/1ps
interface clk_gate_if;
  logic osc_run;
  logic sys_tick;
  logic osc_tick;
  modport ctrl (output osc_run, input sys_tick, input osc_tick);
  modport div (input osc_run, output sys_tick, output osc_tick);
endinterface

// file: logic/osc_divider.sv
// Divider: makes the oscillator tick and the system tick enables.
// Assumes mclk_i is the oscillator rate; div_by 1 or 2.
`timescale 1ns/1ps
module osc_divider #(
  parameter int DIV_BY = clk_ctrl_pkg::CLK_DIV_BY
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  clk_gate_if.div gate
);
  import clk_ctrl_pkg::*;
  logic phase_q;
  logic phase_d;
  // ----------------------------------------
  // Divide chain
  // ----------------------------------------
  always_comb begin
    phase_d = phase_q;
    if (!gate.osc_run) begin
      phase_d = 1'b0;
    end else if (DIV_BY == 2) begin
      phase_d = ~phase_q;
    end
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
    end
  end
  assign gate.osc_tick = gate.osc_run;
  assign gate.sys_tick = gate.osc_run & ((DIV_BY == 2) ? phase_q : 1'b1);
  chk_half_rate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (DIV_BY == 2 && gate.sys_tick) |=> !gate.sys_tick)
    else $error("system tick faster than half oscillator rate");
endmodule

// file: logic/halt_clock_ctrl.sv
// Top: halt state, power modes, warm-up and status pins of the processor.
// Assumes the core reports opcode fetch, halt fetch and its T state.
`timescale 1ns/1ps
module halt_clock_ctrl #(
  parameter int DIV_BY = clk_ctrl_pkg::CLK_DIV_BY,
  parameter int WARM_COUNT = clk_ctrl_pkg::WARM_CYCLES
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic power_mode_select_a_i,
  input wire logic power_mode_select_b_i,
  input wire logic bus_hold_request_n_i,
  input wire logic int_request_n_i,
  input wire logic nmi_request_n_i,
  input wire logic opcode_fetch_i,
  input wire logic int_ack_cycle_i,
  input wire logic halt_fetch_i,
  input wire logic [1:0] t_state_i,
  input wire logic int_accept_i,
  output logic halt_n_o,
  output logic machine_cycle_one_n_o,
  output logic bus_float_o,
  output logic sys_clk_en_o,
  output logic clk_out_o,
  output logic osc_run_o,
  output logic nop_insert_o
);
  import clk_ctrl_pkg::*;
  clk_gate_if gate ();
  pm_state_e state_q;
  pm_state_e state_d;
  logic halted_q;
  logic halted_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic [15:0] warm_q;
  logic [15:0] warm_d;
  logic clk_out_q;
  logic clk_out_d;
  logic cyc_one_n_q;
  logic cyc_one_n_d;
  logic wake;
  logic halt_end;
  logic sleep_now;
  logic [1:0] mode_pins;

  osc_divider #(.DIV_BY(DIV_BY)) u_div (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .gate(gate)
  );

  assign mode_pins = {power_mode_select_a_i, power_mode_select_b_i};
  assign wake = !int_request_n_i || !nmi_request_n_i;
  // ----------------------------------------
  // Halt entry and power state
  // ----------------------------------------
  assign halt_end = halt_fetch_i && t_state_i == FOURTH_STATE && gate.sys_tick;
  // Sleep at T4 of the halt fetch, or of the wake-up no-op without acceptance
  assign sleep_now = (halt_end || (halted_q && t_state_i == FOURTH_STATE &&
                      gate.sys_tick && !int_accept_i)) &&
                     (halt_end ? mode_pins : mode_q) != MODE_RUN;
  always_comb begin
    state_d = state_q;
    halted_d = halted_q;
    mode_d = mode_q;
    if (halted_q && int_accept_i) begin
      halted_d = 1'b0;
    end
    // A new halt fetch in the same cycle wins over the release
    if (halt_end) begin
      halted_d = 1'b1;
      mode_d = mode_pins;
    end
    case (state_q)
      PM_ACTIVE: begin
        if (sleep_now) begin
          state_d = (mode_d == MODE_STOP) ? PM_STOP : PM_IDLE;
        end
      end
      PM_IDLE: begin
        if (wake) begin
          state_d = PM_ACTIVE;
        end
      end
      PM_STOP: begin
        if (wake) begin
          state_d = PM_WARM;
        end
      end
      PM_WARM: begin
        if (warm_q == 16'(WARM_COUNT - 1)) begin
          state_d = PM_ACTIVE;
        end
      end
      default: state_d = PM_ACTIVE;
    endcase
  end
  always_comb begin
    warm_d = 16'h0000;
    if (state_q == PM_WARM) begin
      warm_d = warm_q + 16'h0001;
    end
  end
  // Reset returns straight to active, no warm-up
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= PM_ACTIVE;
      halted_q <= 1'b0;
      mode_q <= MODE_RUN;
      warm_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      halted_q <= halted_d;
      mode_q <= mode_d;
      warm_q <= warm_d;
    end
  end
  // ----------------------------------------
  // Clock enables and outputs
  // ----------------------------------------
  assign gate.osc_run = state_q != PM_STOP && state_q != PM_WARM;
  assign osc_run_o = state_q != PM_STOP;
  assign sys_clk_en_o = gate.sys_tick && state_q == PM_ACTIVE;
  always_comb begin
    clk_out_d = clk_out_q;
    if (state_q == PM_STOP || state_q == PM_WARM ||
        (state_q == PM_IDLE && mode_q == MODE_LIGHT_SLEEP)) begin
      clk_out_d = 1'b0;
    end else if (gate.osc_tick) begin
      clk_out_d = (DIV_BY == 2) ? ~clk_out_q : 1'b1;
    end
  end
  always_comb begin
    cyc_one_n_d = 1'b1;
    if (opcode_fetch_i || int_ack_cycle_i) begin
      cyc_one_n_d = 1'b0;
    end
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_out_q <= 1'b0;
      cyc_one_n_q <= 1'b1;
    end else begin
      clk_out_q <= clk_out_d;
      cyc_one_n_q <= cyc_one_n_d;
    end
  end
  assign clk_out_o = clk_out_q;
  assign machine_cycle_one_n_o = cyc_one_n_q;
  assign halt_n_o = ~halted_q;
  assign nop_insert_o = halted_q && state_q == PM_ACTIVE;
  assign bus_float_o = !bus_hold_request_n_i;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_stop_clk_low: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      state_q == PM_STOP |=> clk_out_o == 1'b0)
    else $error("clock output not low in stop");
  chk_run_no_sleep: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (state_q == PM_ACTIVE && halted_q && mode_q == MODE_RUN) |=> state_q == PM_ACTIVE)
    else $error("run mode left active state");
  chk_warm_bound: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(state_q == PM_WARM) |-> state_q == PM_WARM [*8])
    else $error("warm-up ended too early");
  chk_idle_wake: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (state_q == PM_IDLE && wake) |=> state_q == PM_ACTIVE)
    else $error("idle did not wake on interrupt");
  chk_stop_wake: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (state_q == PM_STOP && wake) |=> state_q == PM_WARM && !gate.osc_run)
    else $error("stop wake skipped warm-up");
  chk_no_halt_run: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (!halted_q && !halt_end) |=> state_q == PM_ACTIVE || $past(halted_q))
    else $error("clock stopped outside halt");
  chk_halt_pin: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      halt_end |=> !halt_n_o)
    else $error("halt status not low after halt fetch");
  chk_cycle_one_fetch: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (opcode_fetch_i || int_ack_cycle_i) |=> !machine_cycle_one_n_o)
    else $error("cycle-one not driven on fetch");
  chk_clkout_sleep: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (state_q == PM_IDLE && mode_q == MODE_LIGHT_SLEEP) |=> !clk_out_o)
    else $error("clock output running in light sleep");
endmodule

// file: verif/core_stub.sv
// Stub core: steps the T state on every internal clock tick.
// Assumes one clock and the controller's tick enable.
`timescale 1ns/1ps
module core_stub (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic tick_i,
  output logic [1:0] t_state_o
);
  always @(negedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      t_state_o <= 2'h0;
    end else if (tick_i) begin
      t_state_o <= t_state_o + 2'h1;
    end
  end
endmodule

// file: verif/test_halt_clock_ctrl.sv
// Testbench: halt entry, power modes, wake-up and status pins.
// Assumes a 100 MHz clock and a short warm-up count.
`timescale 1ns/1ps
module test_halt_clock_ctrl;
  import clk_ctrl_pkg::*;
  localparam int WARM = 20;
  logic mclk_i = 0, nrst_i = 0, sel_a = 0, sel_b = 0, hold_n = 1, int_n = 1, nmi_n = 1;
  logic fetch = 0, ack = 0, hfetch = 0, accept = 0, a;
  logic [1:0] t_state;
  logic halt_n, cyc_one_n, bus_float, tick, clk_out, osc_run, nop;
  int n_errors = 0, comparisons = 0, cyc = 0, k, w;

  halt_clock_ctrl #(.DIV_BY(2), .WARM_COUNT(WARM)) dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .power_mode_select_a_i(sel_a),
    .power_mode_select_b_i(sel_b), .bus_hold_request_n_i(hold_n), .int_request_n_i(int_n),
    .nmi_request_n_i(nmi_n), .opcode_fetch_i(fetch), .int_ack_cycle_i(ack),
    .halt_fetch_i(hfetch), .t_state_i(t_state), .int_accept_i(accept), .halt_n_o(halt_n),
    .machine_cycle_one_n_o(cyc_one_n), .bus_float_o(bus_float), .sys_clk_en_o(tick),
    .clk_out_o(clk_out), .osc_run_o(osc_run), .nop_insert_o(nop));
  core_stub core (.mclk_i(mclk_i), .nrst_i(nrst_i), .tick_i(tick), .t_state_o(t_state));

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  task finish_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      finish_test();
    end
  end

  task check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task cycles(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task ticks(input int n);
    k = 0;
    repeat (n) begin
      @(negedge mclk_i);
      k += (tick === 1'b1);
    end
  endtask

  task do_halt(input logic [1:0] mode);
    {sel_a, sel_b} = mode;
    hfetch = 1;
    for (int i = 0; i < 40 && halt_n !== 1'b0; i++) cycles(1);
    hfetch = 0;
    check(halt_n === 1'b0, "halt status not low");
  endtask

  task wake_accept();
    int_n = 0;
    for (w = 0; w < 100 && tick !== 1'b1; w++) cycles(1);
    accept = 1;
    cycles(1);
    accept = 0;
    int_n = 1;
    cycles(2);
    check(halt_n === 1'b1 && nop === 1'b0, "halt not released");
  endtask

  task t_pins();
    for (int i = 0; i < 3; i++) begin
      fetch = (i < 2);
      ack = (i == 2);
      cycles(1);
      fetch = 0;
      ack = 0;
      check(cyc_one_n === 1'b0, "cycle-one not low");
      cycles(1);
      check(cyc_one_n === 1'b1, "cycle-one stuck low");
    end
    hold_n = 0;
    cycles(1);
    check(bus_float === 1'b1, "bus not floated");
    hold_n = 1;
    cycles(1);
    check(bus_float === 1'b0, "bus still floated");
    {sel_a, sel_b} = MODE_STOP;
    ticks(8);
    check(k == 4 && osc_run === 1'b1, "clock stopped outside halt");
  endtask

  task t_run();
    do_halt(MODE_RUN);
    ticks(8);
    a = clk_out;
    check(k > 0 && nop === 1'b1, "run mode stalled");
    cycles(1);
    check(clk_out !== a, "clock output stopped");
    wake_accept();
  endtask

  task t_sleep(input logic [1:0] mode);
    do_halt(mode);
    cycles(2);
    a = clk_out;
    // Odd count, so a free-running clock output ends on the other level
    ticks(9);
    check(k == 0 && osc_run === 1'b1, "sleep tick or oscillator");
    check((clk_out === a) == (mode == MODE_LIGHT_SLEEP), "clock output");
    int_n = 0;
    cycles(3);
    int_n = 1;
    cycles(20);
    ticks(10);
    check(k == 0 && halt_n === 1'b0, "no resleep after idle wake");
    wake_accept();
  endtask

  task t_stop();
    do_halt(MODE_STOP);
    cycles(2);
    check(osc_run === 1'b0 && clk_out === 1'b0, "stop not entered");
    wake_accept();
    check(w >= WARM && w < WARM + 10, "warm-up length");
    do_halt(MODE_STOP);
    nrst_i = 0;
    cycles(3);
    nrst_i = 1;
    ticks(6);
    check(k > 0 && osc_run === 1'b1, "reset wake slow");
  endtask

  initial begin
    cycles(16);
    nrst_i = 1;
    cycles(2);
    t_pins();
    t_run();
    t_sleep(MODE_LIGHT_SLEEP);
    t_sleep(MODE_CLOCK_OUT_SLEEP);
    t_stop();
    finish_test();
  end
endmodule
